/* hw/sbsc_ctrl.sv */
`timescale 1ns/10ps
module sbsc_ctrl #(
    parameter int ADDR_W = sbsc_pkg::ADDR_W,
    parameter int LANES = sbsc_pkg::LANES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Synchronous pins from the controller
    input wire logic clock_qualify_n,
    input wire sbsc_pkg::sbsc_pins_s pins,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    // Array side
    output logic [ADDR_W-1:0] mem_addr,
    output logic [LANES-1:0] mem_lane_we,
    output logic mem_read,
    output logic [1:0] addr_burst,
    output logic data_drive_en,
    output logic sleeping
);
    // ----------------------------------------------------------------
    // Input capture
    // ----------------------------------------------------------------
    // Pins may change on the edge, so every one passes two flops
    sbsc_pkg::sbsc_pins_s pins_s;
    logic qual_s;
    logic oe_n_s;
    logic sleep_s;
    logic qual;

    // Qualify is inverted ahead of the flops: their reset value of zero
    // then reads as a suspended clock, so no edge is taken after reset
    sbsc_sync2 #(.W($bits(sbsc_pkg::sbsc_pins_s) + 3)) sbsc_sync2_inst (
        .clock(clock),
        .rst_n(rst_n),
        .d({pins, !clock_qualify_n, output_enable_n, sleep_request}),
        .q({pins_s, qual_s, oe_n_s, sleep_s})
    );

    assign qual = qual_s;

    function automatic logic selected(input sbsc_pkg::sbsc_pins_s p);
        selected = !p.select_first_n && p.select_second
            && !p.select_third_n;
    endfunction

    // ----------------------------------------------------------------
    // Cycle state
    // ----------------------------------------------------------------
    sbsc_pkg::sbsc_op_e op_r;
    sbsc_pkg::sbsc_op_e op_nxt;
    logic [ADDR_W-1:0] base_r;
    logic [1:0] burst_r;
    logic [LANES-1:0] lanes_r;
    logic fresh_r;
    logic sleep_r;

    always_comb
    begin
        op_nxt = op_r;
        if (pins_s.advance_or_load)
        begin
            // Advance never revives a deselected device
            if (op_r == sbsc_pkg::SBSC_DESEL)
                op_nxt = sbsc_pkg::SBSC_DESEL;
        end
        else if (!selected(pins_s))
            op_nxt = sbsc_pkg::SBSC_DESEL;
        else if (!pins_s.write_n)
            op_nxt = sbsc_pkg::SBSC_WRITE;
        else
            op_nxt = sbsc_pkg::SBSC_READ;
    end

    // Held when qualify is high: the previous cycle is extended
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            op_r <= sbsc_pkg::SBSC_DESEL;
        else if (qual && !sleep_r)
            op_r <= op_nxt;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            base_r <= '0;
            burst_r <= sbsc_pkg::BURST_RST;
        end
        else if (qual && !sleep_r)
        begin
            if (!pins_s.advance_or_load)
            begin
                base_r <= pins_s.addr;
                burst_r <= pins_s.addr[1:0];
            end
            else if (op_r != sbsc_pkg::SBSC_DESEL)
                burst_r <= burst_r + 2'h1;
        end
    end

    // Lane enables are taken at each qualified edge outside sleep, also during a burst
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            lanes_r <= '0;
        else if (qual && !sleep_r)
            lanes_r <= ~pins_s.lane_write_n;
    end

    // First access after deselect keeps the drivers off for one qualified cycle, however many clocks it spans
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            fresh_r <= 1'b0;
        else if (qual && !sleep_r)
            fresh_r <= (op_r == sbsc_pkg::SBSC_DESEL)
                && (op_nxt != sbsc_pkg::SBSC_DESEL);
    end

    // Sleep is taken at every clock edge, qualified or not; stored data is untouched
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            sleep_r <= 1'b0;
        else
            sleep_r <= sleep_s;
    end

    // ----------------------------------------------------------------
    // Outputs to the array
    // ----------------------------------------------------------------
    logic active;
    assign active = !sleep_r && qual;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_addr <= '0;
            addr_burst <= sbsc_pkg::BURST_RST;
            mem_lane_we <= '0;
            mem_read <= 1'b0;
            data_drive_en <= 1'b0;
            sleeping <= 1'b0;
        end
        else
        begin
            mem_addr <= {base_r[ADDR_W-1:2], burst_r};
            addr_burst <= burst_r;
            mem_lane_we <= (op_r == sbsc_pkg::SBSC_WRITE && active)
                ? lanes_r : '0;
            mem_read <= op_r == sbsc_pkg::SBSC_READ && active;
            // Registered gate: oe alone cannot open the drivers
            data_drive_en <= !oe_n_s && op_r == sbsc_pkg::SBSC_READ
                && !fresh_r && !sleep_r;
            sleeping <= sleep_r;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_hold_on_qual: assert property (@(posedge clock) disable iff (!rst_n)
        !qual |=> $stable(op_r) && $stable(burst_r))
        else $error("state moved while clock qualify high");
    chk_burst_step: assert property (@(posedge clock) disable iff (!rst_n)
        qual && !sleep_r && pins_s.advance_or_load
        && op_r != sbsc_pkg::SBSC_DESEL
        |=> burst_r == $past(burst_r) + 2'h1)
        else $error("burst counter did not step");
    chk_addr_load: assert property (@(posedge clock) disable iff (!rst_n)
        qual && !sleep_r && !pins_s.advance_or_load
        |=> base_r == $past(pins_s.addr)
        && burst_r == $past(pins_s.addr[1:0]))
        else $error("address not loaded");
    chk_desel_stays: assert property (@(posedge clock) disable iff (!rst_n)
        op_r == sbsc_pkg::SBSC_DESEL && pins_s.advance_or_load
        |=> op_r == sbsc_pkg::SBSC_DESEL)
        else $error("advance resumed a deselected device");
    chk_select_decode: assert property (@(posedge clock) disable iff (!rst_n)
        qual && !sleep_r && !pins_s.advance_or_load && !selected(pins_s)
        |=> op_r == sbsc_pkg::SBSC_DESEL)
        else $error("select decode wrong");
    chk_write_needs_we: assert property (@(posedge clock) disable iff (!rst_n)
        qual && !sleep_r && !pins_s.advance_or_load && pins_s.write_n
        |=> op_r != sbsc_pkg::SBSC_WRITE)
        else $error("write started without write enable");
    chk_lane_gate: assert property (@(posedge clock) disable iff (!rst_n)
        mem_lane_we != '0 |-> $past(op_r) == sbsc_pkg::SBSC_WRITE
        && mem_lane_we == $past(lanes_r))
        else $error("lane written without write");
    chk_drive_off: assert property (@(posedge clock) disable iff (!rst_n)
        data_drive_en |-> $past(op_r) == sbsc_pkg::SBSC_READ
        && !$past(fresh_r) && !$past(oe_n_s))
        else $error("drivers on in wrong cycle");
    chk_sleep_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        sleeping |-> mem_lane_we == '0 && !mem_read)
        else $error("array active while sleeping");
    chk_qual_only: assert property (@(posedge clock) disable iff (!rst_n)
        !qual |=> $stable(lanes_r) && $stable(base_r))
        else $error("input taken with clock qualify high");

    cov_write: cover property (@(posedge clock) disable iff (!rst_n)
        mem_lane_we == '1);
    cov_burst: cover property (@(posedge clock) disable iff (!rst_n)
        mem_read && addr_burst == 2'h3);
    cov_drive: cover property (@(posedge clock) disable iff (!rst_n)
        data_drive_en);
    cov_sleep: cover property (@(posedge clock) disable iff (!rst_n)
        sleeping);
endmodule

/* hw/sbsc_pkg.sv */
package sbsc_pkg;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int BURST_W = 2;
    localparam logic [1:0] BURST_RST = 2'h0;

    // ----------------------------------------------------------------
    // Sampled pin group
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lane_write_n;
        logic write_n;
        logic advance_or_load;
        logic select_first_n;
        logic select_second;
        logic select_third_n;
    } sbsc_pins_s;

    typedef enum logic [1:0] {
        SBSC_DESEL,
        SBSC_READ,
        SBSC_WRITE
    } sbsc_op_e;

endpackage

/* hw/sbsc_sync2.sv */
`timescale 1ns/10ps
module sbsc_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // Two stages; only the second stage is read by the block
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

/* tb/sbsc_host_model.sv */
`timescale 1ns/10ps
module sbsc_host_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Stimulus from the bench
    input wire logic [31:0] rnd,
    input wire logic pause,
    // Pins toward the device
    output logic clock_qualify_n,
    output sbsc_pkg::sbsc_pins_s pins,
    output logic output_enable_n
);
    logic active_r;
    logic act_now;
    logic bad_sel;
    // ----------------------------------------------------------------
    // Selection state as the device will see it after this edge
    // ----------------------------------------------------------------
    assign bad_sel = (rnd[5:3] == 3'h0);
    assign act_now = (!clock_qualify_n && !pins.advance_or_load) ?
        (!pins.select_first_n && pins.select_second &&
         !pins.select_third_n) : active_r;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            active_r <= 1'b0;
        else
            active_r <= act_now;
    end
    // ----------------------------------------------------------------
    // Random but legal pin traffic
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clock_qualify_n <= 1'b1;
            pins <= '0;
            output_enable_n <= 1'b1;
        end
        else
        begin
            clock_qualify_n <= pause | (rnd[0] & rnd[1]);
            pins.addr <= rnd[31:12];
            pins.lane_write_n <= rnd[12:9];
            pins.write_n <= rnd[8];
            // Never advance out of a deselect, a load must come first
            pins.advance_or_load <= rnd[2] & act_now;
            pins.select_first_n <= bad_sel & (rnd[7:6] == 2'h0);
            pins.select_second <= !(bad_sel & (rnd[7:6] == 2'h1));
            pins.select_third_n <= bad_sel & rnd[7];
            output_enable_n <= rnd[13];
        end
    end
endmodule

/* tb/sync_burst_sram_control_pins_bench.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module sync_burst_sram_control_pins_bench;
    logic clock;
    logic rst_n = 1'b0;
    logic pause = 1'b1;
    logic sleep_request = 1'b0;
    logic clock_qualify_n;
    logic output_enable_n;
    sbsc_pkg::sbsc_pins_s pins;
    logic [31:0] seed = 32'ha46b_f866;
    logic [31:0] rnd = 32'h0000_0000;
    logic [sbsc_pkg::ADDR_W-1:0] mem_addr;
    logic [3:0] mem_lane_we;
    logic mem_read;
    logic data_drive_en;
    logic sleeping;
    logic [1:0] addr_burst;
    logic [25:0] expq[$];
    logic [25:0] exp_v;
    logic [25:0] got_v;
    logic [24:0] pend_v = 25'h000_0000;
    logic pend = 1'b0;
    logic fresh = 1'b0;
    logic slp_d = 1'b0;
    logic [19:0] base;
    logic [1:0] cnt;
    logic act = 1'b0;
    logic wr = 1'b0;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    sbsc_host_model sbsc_host_model_inst (.clock(clock), .rst_n(rst_n),
        .rnd(rnd), .pause(pause), .clock_qualify_n(clock_qualify_n),
        .pins(pins), .output_enable_n(output_enable_n));
    sbsc_ctrl sbsc_ctrl_inst (.clock(clock), .rst_n(rst_n),
        .clock_qualify_n(clock_qualify_n), .pins(pins),
        .output_enable_n(output_enable_n), .sleep_request(sleep_request),
        .mem_addr(mem_addr), .mem_lane_we(mem_lane_we),
        .mem_read(mem_read), .addr_burst(addr_burst),
        .data_drive_en(data_drive_en), .sleeping(sleeping));

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task give_verdict;
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // ----------------------------------------------------------------
    // Predictor: follows each qualified edge outside sleep in pin order
    // ----------------------------------------------------------------
    always @(posedge clock)
    begin
        if (rst_n && !clock_qualify_n && !slp_d)
        begin
            // A held access reaches the array only at the next live edge
            if (pend)
                expq.push_back({pend_v, !output_enable_n && pend_v[0]
                    && !fresh});
            if (!pins.advance_or_load)
            begin
                fresh = !act;
                act = !pins.select_first_n && pins.select_second &&
                    !pins.select_third_n;
                fresh = fresh && act;
                base = pins.addr;
                cnt = pins.addr[1:0];
                wr = !pins.write_n;
            end
            else
            begin
                fresh = 1'b0;
                if (act)
                    cnt = cnt + 2'h1;
            end
            pend = act && (!wr || pins.lane_write_n != 4'hf);
            pend_v = {base[19:2], cnt, wr ? ~pins.lane_write_n : 4'h0,
                !wr};
        end
        // Sleep reaches the device state one edge after the pins do
        slp_d = sleep_request;
    end
    // ----------------------------------------------------------------
    // Monitor and hang guard
    // ----------------------------------------------------------------
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            num_errors++;
            give_verdict;
        end
        else if (rst_n && (mem_read || mem_lane_we != 4'h0))
        begin
            exp_v = (expq.size() > 0) ? expq.pop_front() : 26'h3ff_ffff;
            got_v = {mem_addr, mem_lane_we, mem_read, data_drive_en};
            `CHK(got_v, exp_v)
            `CHK(addr_burst, exp_v[7:6])
            if (mem_lane_we != 4'h0)
                `CHK(data_drive_en, 1'b0)
        end
    end

    initial
    begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        pause <= 1'b0;
        for (int i = 0; i < 4000; i++)
        begin
            @(posedge clock);
            seed = xs(seed);
            rnd <= seed;
            // Short naps inside live traffic must freeze the device
            sleep_request <= (i % 500) > 450 && (i % 500) < 480;
        end
        // Deselecting loads let the last held access reach the array
        @(posedge clock);
        rnd <= 32'h0000_0000;
        repeat (4) @(posedge clock);
        pause <= 1'b1;
        repeat (10) @(posedge clock);
        `CHK(expq.size(), 0)
        sleep_request <= 1'b1;
        for (int i = 0; i < 20 && sleeping !== 1'b1; i++)
            @(posedge clock);
        `CHK(sleeping, 1'b1)
        sleep_request <= 1'b0;
        for (int i = 0; i < 20 && sleeping !== 1'b0; i++)
            @(posedge clock);
        `CHK(sleeping, 1'b0)
        give_verdict;
    end
endmodule
